/* File: hdl/serial_output_enable_config.sv */
`timescale 1ns/1ps
module serial_output_enable_config (
  input  wire logic                                          core_clk,
  input  wire logic                                          arst_n,
  input  wire logic                                          link_clk,
  input  wire logic                                          serial_clock_line,
  input  wire logic                                          serial_data_line_i,
  input  wire logic                                          buffer_clock_in,
  output logic                                               serial_data_line_o,
  output logic                                               serial_data_line_oe,
  output logic [clock_buffer_cfg_pkg::NUM_OUTPUTS-1:0]       buffered_clock_outputs,
  output logic [clock_buffer_cfg_pkg::NUM_OUTPUTS-1:0]       output_enable_state
);
  import clock_buffer_cfg_pkg::*;

  // ************************************************************
  // Link line synchronisers
  // ************************************************************
  logic [1:0]            line_sync;
  logic                  scl_s;
  logic                  sda_s;
  logic                  scl_prev;
  logic                  sda_prev;
  logic                  next_scl_prev;
  logic                  next_sda_prev;
  logic                  scl_rise;
  logic                  scl_fall;
  logic                  start_cond;
  logic                  stop_cond;

  bit_sync #(
    .WIDTH       (2),
    .RESET_VALUE (LINE_SYNC_RESET)
  ) u_line_sync (
    .clk    (link_clk),
    .arst_n (arst_n),
    .d      ({serial_clock_line, serial_data_line_i}),
    .q      (line_sync)
  );

  assign scl_s = line_sync[1];
  assign sda_s = line_sync[0];

  always_comb begin
    next_scl_prev = scl_s;
    next_sda_prev = sda_s;
  end

  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_prev <= next_scl_prev;
      sda_prev <= next_sda_prev;
    end
  end

  // ************************************************************
  // Edge and framing detection
  // ************************************************************
  always_comb begin
    scl_rise   = scl_s && !scl_prev;
    scl_fall   = !scl_s && scl_prev;
    start_cond = scl_s && scl_prev && sda_prev && !sda_s;
    stop_cond  = scl_s && scl_prev && !sda_prev && sda_s;
  end

  // ************************************************************
  // Receive state machine
  // ************************************************************
  link_state_t           state;
  link_state_t           next_state;
  logic [2:0]            bit_cnt;
  logic [2:0]            next_bit_cnt;
  logic [3:0]            byte_idx;
  logic [3:0]            next_byte_idx;
  logic [7:0]            shift;
  logic [7:0]            next_shift;
  logic                  ack_drive;
  logic                  next_ack_drive;
  logic [7:0]            output_enable_low_group;
  logic [7:0]            output_enable_mid_group;
  logic [7:0]            output_enable_high_group;
  logic [7:0]            next_low_group;
  logic [7:0]            next_mid_group;
  logic [7:0]            next_high_group;
  logic [2:0]            bit_pos;
  logic [7:0]            full_byte;
  logic                  pend_valid;
  logic                  next_pend_valid;

  always_comb begin
    next_state      = state;
    next_bit_cnt    = bit_cnt;
    next_byte_idx   = byte_idx;
    next_shift      = shift;
    next_ack_drive  = ack_drive;
    next_pend_valid = pend_valid;
    next_low_group  = output_enable_low_group;
    next_mid_group  = output_enable_mid_group;
    next_high_group = output_enable_high_group;
    bit_pos         = 3'(LAST_BIT - bit_cnt + 3'h1);
    full_byte       = {shift[6:0], sda_s};
    if (start_cond) begin
      next_state     = st_receive;
      next_bit_cnt   = 3'h0;
      next_byte_idx  = IDX_ADDRESS;
      next_ack_drive = 1'b0;
      next_pend_valid = 1'b0;
    end else if (stop_cond) begin
      next_state     = st_idle;
      next_bit_cnt   = 3'h0;
      next_ack_drive = 1'b0;
      next_pend_valid = 1'b0;
    end else begin
      // Bit lands in the live enables once its high phase ends cleanly
      if (scl_fall && pend_valid) begin
        next_pend_valid = 1'b0;
        if (byte_idx == IDX_DATA0) begin
          next_low_group[bit_pos] = shift[0];
        end
        if (byte_idx == IDX_DATA1) begin
          next_mid_group[bit_pos] = shift[0];
        end
        if (byte_idx == IDX_DATA2) begin
          next_high_group[bit_pos] = shift[0];
        end
      end
      unique case (state)
        st_idle, st_ignore: begin
          next_ack_drive = 1'b0;
        end
        st_receive: begin
          if (scl_rise) begin
            next_shift      = full_byte;
            next_bit_cnt    = 3'(bit_cnt + 3'h1);
            next_pend_valid = (byte_idx >= IDX_DATA0) && (byte_idx <= IDX_DATA2);
            if (bit_cnt == LAST_BIT) begin
              if (byte_idx == IDX_ADDRESS && full_byte != DEVICE_WRITE_ADDR) begin
                next_state = st_ignore;
              end else begin
                next_state = st_ack_wait;
              end
            end
          end
        end
        st_ack_wait: begin
          if (scl_fall) begin
            next_state     = st_ack;
            next_ack_drive = 1'b1;
          end
        end
        st_ack: begin
          if (scl_fall) begin
            next_state     = st_receive;
            next_ack_drive = 1'b0;
            next_bit_cnt   = 3'h0;
            if (byte_idx != IDX_LAST) begin
              next_byte_idx = 4'(byte_idx + 4'h1);
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      state                    <= st_idle;
      bit_cnt                  <= 3'h0;
      byte_idx                 <= IDX_ADDRESS;
      shift                    <= 8'h00;
      ack_drive                <= 1'b0;
      pend_valid               <= 1'b0;
      output_enable_low_group  <= LOW_GROUP_RESET;
      output_enable_mid_group  <= MID_GROUP_RESET;
      output_enable_high_group <= HIGH_GROUP_RESET;
    end else begin
      state                    <= next_state;
      bit_cnt                  <= next_bit_cnt;
      byte_idx                 <= next_byte_idx;
      shift                    <= next_shift;
      ack_drive                <= next_ack_drive;
      pend_valid               <= next_pend_valid;
      output_enable_low_group  <= next_low_group;
      output_enable_mid_group  <= next_mid_group;
      output_enable_high_group <= next_high_group;
    end
  end

  // ************************************************************
  // Open-drain data line
  // ************************************************************
  always_comb begin
    serial_data_line_o  = 1'b0;
    serial_data_line_oe = ack_drive;
  end

  // ************************************************************
  // Enable crossing and output gating
  // ************************************************************
  logic [NUM_OUTPUTS-1:0] enable_link;

  assign enable_link = {output_enable_high_group[HIGH_FIELD_MSB:HIGH_FIELD_LSB],
                        output_enable_mid_group[MID_FIELD_MSB:MID_FIELD_LSB],
                        output_enable_low_group[LOW_FIELD_MSB:LOW_FIELD_LSB]};

  bit_sync #(
    .WIDTH       (NUM_OUTPUTS),
    .RESET_VALUE (ENABLE_RESET)
  ) u_enable_sync (
    .clk    (core_clk),
    .arst_n (arst_n),
    .d      (enable_link),
    .q      (output_enable_state)
  );

  clock_output_gate #(
    .WIDTH (NUM_OUTPUTS)
  ) u_gate (
    .clock_in  (buffer_clock_in),
    .enable    (output_enable_state),
    .clock_out (buffered_clock_outputs)
  );

  // ************************************************************
  // Checks
  // ************************************************************
  sequence s_byte_end;
    state == st_receive && scl_rise && !start_cond && !stop_cond && bit_cnt == LAST_BIT;
  endsequence

  sequence s_ack_fall;
    state == st_ack_wait && scl_fall && !start_cond && !stop_cond;
  endsequence

  property p_msb_first;
    @(posedge link_clk) disable iff (!arst_n)
    (scl_fall && pend_valid && byte_idx == IDX_DATA0 && bit_cnt == 3'h1)
    |=> output_enable_low_group[7] == $past(shift[0]);
  endproperty
  a_msb_first: assert property (p_msb_first)
    else $error("first data bit not stored at bit 7");

  property p_disabled_low;
    @(posedge core_clk) disable iff (!arst_n)
    (buffered_clock_outputs & ~output_enable_state) == 10'h000;
  endproperty
  a_disabled_low: assert property (p_disabled_low)
    else $error("disabled output not held low");

  property p_ack_only;
    @(posedge link_clk) disable iff (!arst_n)
    serial_data_line_oe |-> (state == st_ack || $past(state) == st_ack);
  endproperty
  a_ack_only: assert property (p_ack_only)
    else $error("data line driven outside acknowledge");

  property p_ack_ninth;
    @(posedge link_clk) disable iff (!arst_n)
    s_ack_fall |=> serial_data_line_oe && state == st_ack;
  endproperty
  a_ack_ninth: assert property (p_ack_ninth)
    else $error("acknowledge not driven after eighth bit");

  property p_ignore_stable;
    @(posedge link_clk) disable iff (!arst_n)
    (state == st_ignore || state == st_idle) |=>
      $stable(output_enable_low_group) && $stable(output_enable_mid_group) &&
      $stable(output_enable_high_group);
  endproperty
  a_ignore_stable: assert property (p_ignore_stable)
    else $error("enables changed outside an addressed write");

  property p_restart;
    @(posedge link_clk) disable iff (!arst_n)
    start_cond |=> state == st_receive && byte_idx == IDX_ADDRESS && bit_cnt == 3'h0;
  endproperty
  a_restart: assert property (p_restart)
    else $error("start did not restart reception");

  property p_stop;
    @(posedge link_clk) disable iff (!arst_n)
    (stop_cond && !start_cond) |=> state == st_idle && !serial_data_line_oe;
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop did not end reception");

  property p_bad_address;
    @(posedge link_clk) disable iff (!arst_n)
    (s_byte_end and (byte_idx == IDX_ADDRESS && full_byte != DEVICE_WRITE_ADDR))
    |=> (state == st_ignore) [*2];
  endproperty
  a_bad_address: assert property (p_bad_address)
    else $error("wrong address not ignored");

  property p_unused_bytes;
    @(posedge link_clk) disable iff (!arst_n)
    (state == st_receive && byte_idx != IDX_DATA0 && byte_idx != IDX_DATA1 &&
     byte_idx != IDX_DATA2) |=>
      $stable(output_enable_low_group) && $stable(output_enable_mid_group) &&
      $stable(output_enable_high_group);
  endproperty
  a_unused_bytes: assert property (p_unused_bytes)
    else $error("non-data byte changed enables");

  property p_data_acked;
    @(posedge link_clk) disable iff (!arst_n)
    (s_byte_end and (byte_idx != IDX_ADDRESS)) |=> state == st_ack_wait;
  endproperty
  a_data_acked: assert property (p_data_acked)
    else $error("data byte not headed for acknowledge");

endmodule

/* File: hdl/clock_buffer_cfg_pkg.sv */
package clock_buffer_cfg_pkg;

  // ************************************************************
  // Serial framing
  // ************************************************************
  localparam logic [7:0] DEVICE_WRITE_ADDR = 8'hD2;
  localparam logic [2:0] LAST_BIT          = 3'h7;
  localparam logic [3:0] IDX_ADDRESS       = 4'h0;
  localparam logic [3:0] IDX_COMMAND       = 4'h1;
  localparam logic [3:0] IDX_COUNT         = 4'h2;
  localparam logic [3:0] IDX_DATA0         = 4'h3;
  localparam logic [3:0] IDX_DATA1         = 4'h4;
  localparam logic [3:0] IDX_DATA2         = 4'h5;
  localparam logic [3:0] IDX_LAST          = 4'h9;

  // ************************************************************
  // Enable groups
  // ************************************************************
  localparam int         NUM_OUTPUTS       = 10;
  localparam int         LOW_FIELD_MSB     = 3;
  localparam int         LOW_FIELD_LSB     = 0;
  localparam int         MID_FIELD_MSB     = 7;
  localparam int         MID_FIELD_LSB     = 4;
  localparam int         HIGH_FIELD_MSB    = 7;
  localparam int         HIGH_FIELD_LSB    = 6;
  localparam logic [7:0] LOW_GROUP_RESET   = 8'hFF;
  localparam logic [7:0] MID_GROUP_RESET   = 8'hFF;
  localparam logic [7:0] HIGH_GROUP_RESET  = 8'hFF;
  localparam logic [9:0] ENABLE_RESET      = 10'h3FF;
  localparam logic [1:0] LINE_SYNC_RESET   = 2'h3;

  // ************************************************************
  // Link states
  // ************************************************************
  typedef enum logic [2:0] {
    st_idle,
    st_receive,
    st_ack_wait,
    st_ack,
    st_ignore
  } link_state_t;

endpackage

/* File: hdl/bit_sync.sv */
`timescale 1ns/1ps
module bit_sync #(
  parameter int                 WIDTH       = 1,
  parameter logic [WIDTH-1:0]   RESET_VALUE = '0
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] stage;
  logic [WIDTH-1:0] next_stage;
  logic [WIDTH-1:0] next_q;

  // ************************************************************
  // Two flip-flop crossing
  // ************************************************************
  always_comb begin
    next_stage = d;
    next_q     = stage;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stage <= RESET_VALUE;
      q     <= RESET_VALUE;
    end else begin
      stage <= next_stage;
      q     <= next_q;
    end
  end

endmodule

/* File: hdl/clock_output_gate.sv */
`timescale 1ns/1ps
module clock_output_gate #(
  parameter int                 WIDTH = 1
) (
  input  wire logic             clock_in,
  input  wire logic [WIDTH-1:0] enable,
  output logic      [WIDTH-1:0] clock_out
);

  // ************************************************************
  // Follow input clock or hold low
  // ************************************************************
  always_comb begin
    clock_out = {WIDTH{clock_in}} & enable;
  end

endmodule

/* File: testbench/smbus_host_model.sv */
`timescale 1ns/1ps
// ************************************************************
// Write-only bus host, open drain on both lines
// ************************************************************
module smbus_host_model (
  input  wire logic clk,
  input  wire logic sda_wire,
  output logic      scl_low,
  output logic      sda_low
);
  int q = 6;
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  task automatic pause(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Start or restart, data falls under high clock
  task automatic start_cond();
    sda_low = 1'b0;
    pause(q);
    scl_low = 1'b0;
    pause(2 * q);
    sda_low = 1'b1;
    pause(q);
    scl_low = 1'b1;
    pause(q);
  endtask
  // Only pull low or release
  task automatic send_bit(input logic b);
    sda_low = ~b;
    pause(q);
    scl_low = 1'b0;
    pause(2 * q);
    scl_low = 1'b1;
    pause(q);
  endtask
  task automatic get_ack(output logic ack);
    sda_low = 1'b0;
    pause(q);
    scl_low = 1'b0;
    pause(q);
    ack = ~sda_wire;
    pause(q);
    scl_low = 1'b1;
    pause(q);
  endtask
  task automatic stop_cond();
    sda_low = 1'b1;
    pause(q);
    scl_low = 1'b0;
    pause(2 * q);
    sda_low = 1'b0;
    pause(q);
  endtask
endmodule

/* File: testbench/serial_output_enable_config_tb_top.sv */
`timescale 1ns/1ps
module serial_output_enable_config_tb_top;
  import clock_buffer_cfg_pkg::*;
  logic                   core_clk;
  logic                   link_clk;
  logic                   arst_n;
  logic                   buffer_clock_in;
  logic                   scl_low;
  logic                   sda_low;
  logic                   sda_o;
  logic                   sda_oe;
  logic                   scl_wire;
  logic                   sda_wire;
  logic [NUM_OUTPUTS-1:0] outs;
  logic [NUM_OUTPUTS-1:0] en_state;
  logic [7:0]             model_reg [3];
  logic [7:0]             fr [$];
  int                     n_fail;
  int                     cmp_count;
  assign scl_wire = ~scl_low;
  assign sda_wire = ~(sda_low | (sda_oe & ~sda_o));
  // ************************************************************
  // Clocks, design, host
  // ************************************************************
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #24 link_clk = ~link_clk;
  end
  serial_output_enable_config dut (
    .core_clk               (core_clk),
    .arst_n                 (arst_n),
    .link_clk               (link_clk),
    .serial_clock_line      (scl_wire),
    .serial_data_line_i     (sda_wire),
    .buffer_clock_in        (buffer_clock_in),
    .serial_data_line_o     (sda_o),
    .serial_data_line_oe    (sda_oe),
    .buffered_clock_outputs (outs),
    .output_enable_state    (en_state)
  );
  smbus_host_model host (
    .clk      (core_clk),
    .sda_wire (sda_wire),
    .scl_low  (scl_low),
    .sda_low  (sda_low)
  );
  // ************************************************************
  // Reference model and checks
  // ************************************************************
  function automatic logic [9:0] exp_en();
    return {model_reg[2][7:6], model_reg[1][7:4], model_reg[0][3:0]};
  endfunction
  task automatic check(input logic [9:0] seen, input logic [9:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask
  task automatic check_outputs();
    repeat (10) @(negedge core_clk);
    check(en_state, exp_en(), "enables");
    buffer_clock_in = 1'b1;
    @(negedge core_clk);
    check(outs, exp_en(), "gated high");
    buffer_clock_in = 1'b0;
    @(negedge core_clk);
    check(outs, 10'h000, "gated low");
  endtask
  // Sends fr bit by bit up to cut bits, model follows each bit of fr[3] to fr[5] once the address matched
  task automatic frame(input int cut, input bit stop);
    int  nbit;
    bit  hit;
    logic ack;
    nbit = 0;
    hit = 1'b0;
    host.start_cond();
    foreach (fr[i]) begin
      for (int j = 7; j >= 0; j--) begin
        if (nbit < cut) begin
          host.send_bit(fr[i][j]);
          if (hit && i >= 3 && i <= 5) model_reg[i-3][j] = fr[i][j];
          nbit++;
        end
      end
      if (nbit == 8 * (i + 1)) begin
        if (i == 0) hit = (fr[0] == DEVICE_WRITE_ADDR);
        host.get_ack(ack);
        check({9'h000, ack}, {9'h000, hit}, "ack");
      end
    end
    if (stop) host.stop_cond();
  endtask
  task automatic rand_frame(input logic [7:0] addr);
    fr = {addr};
    repeat (9) fr.push_back(8'($urandom));
  endtask
  task automatic end_of_test();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge core_clk);
    n_fail++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    end_of_test();
  end
  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    logic [7:0] a;
    n_fail = 0;
    cmp_count = 0;
    arst_n = 1'b0;
    buffer_clock_in = 1'b0;
    foreach (model_reg[k]) model_reg[k] = 8'hFF;
    void'($urandom(46));
    repeat (20) @(negedge core_clk);
    arst_n = 1'b1;
    repeat (10) @(negedge core_clk);
    check(en_state, 10'h3FF, "reset enables");
    check_outputs();
    $display("Test reset done");
    for (int n = 0; n < 4; n++) begin
      host.q = (n % 2 == 1) ? 12 : 6;
      rand_frame(DEVICE_WRITE_ADDR);
      if (n < 3) begin
        fr[3] = fr[3] & 8'h0F;
        fr[4] = fr[4] & 8'hF0;
      end
      frame(80, 1'b1);
      check_outputs();
    end
    host.q = 6;
    $display("Test full writes done");
    do a = 8'($urandom); while (a == DEVICE_WRITE_ADDR);
    rand_frame(a);
    frame(80, 1'b1);
    check_outputs();
    $display("Test foreign address done");
    for (int n = 0; n < 3; n++) begin
      rand_frame(DEVICE_WRITE_ADDR);
      frame(25 + int'($urandom_range(14)), 1'b1);
      check_outputs();
    end
    $display("Test truncated stop done");
    rand_frame(DEVICE_WRITE_ADDR);
    frame(35, 1'b0);
    rand_frame(DEVICE_WRITE_ADDR);
    frame(80, 1'b1);
    check_outputs();
    $display("Test restart done");
    end_of_test();
  end
endmodule
